// *** core/gauge_pkg.sv ***
// Shared constants and types for the charge gauge pin and counter logic
package gauge_pkg;

    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [5:0] IDX_STATUS = 6'h00;  // Sticky status
    localparam logic [5:0] IDX_CTRL   = 6'h01;  // Control
    localparam logic [5:0] IDX_CHG_HI = 6'h02;  // Charge upper byte
    localparam logic [5:0] IDX_CHG_LO = 6'h03;  // Charge lower byte
    localparam logic [5:0] IDX_THH_HI = 6'h04;  // High limit upper byte
    localparam logic [5:0] IDX_THH_LO = 6'h05;  // High limit lower byte
    localparam logic [5:0] IDX_THL_HI = 6'h06;  // Low limit upper byte
    localparam logic [5:0] IDX_THL_LO = 6'h07;  // Low limit lower byte
    localparam logic [5:0] IDX_MASK   = 6'h08;  // Interrupt mask
    localparam logic [5:0] IDX_LINK   = 6'h09;  // Serial line monitor

    // ------------------------------------------------------------
    // Reset values and charge saturation ends
    // ------------------------------------------------------------
    localparam logic [7:0]  CTRL_RST   = 8'h3C;
    localparam logic [15:0] CHARGE_RST = 16'h7FFF;
    localparam logic [15:0] THR_HI_RST = 16'hFFFF;
    localparam logic [15:0] THR_LO_RST = 16'h0000;
    localparam logic [7:0]  MASK_RST   = 8'h00;
    localparam logic [15:0] CHARGE_TOP = 16'hFFFF;
    localparam logic [15:0] CHARGE_BOT = 16'h0000;

    // ------------------------------------------------------------
    // Field codes and status bit positions
    // ------------------------------------------------------------
    localparam logic [1:0] PIN_ALERT  = 2'h2;   // Open-drain alert
    localparam logic [1:0] PIN_CHARGE = 2'h1;   // Charge-done input
    localparam logic [1:0] VBAT_OFF   = 2'h0;
    localparam logic [1:0] VBAT_2V8   = 2'h1;
    localparam logic [1:0] VBAT_2V9   = 2'h2;
    localparam logic [1:0] VBAT_3V0   = 2'h3;
    localparam int ST_UVLO = 0;
    localparam int ST_VBAT = 1;
    localparam int ST_LOW  = 2;
    localparam int ST_HIGH = 3;
    localparam int ST_OVF  = 5;
    localparam logic [7:0] ST_USED = 8'h2F;     // Implemented sticky bits

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_NS     = 40;
    localparam int CC_MIN_NS  = 1000;
    localparam int CC_MIN_CYC = (CC_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int CC_FILT_CYC = CC_MIN_CYC / 2;   // Glitch filter

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0] vbatSel;    // Battery threshold code
        logic [2:0] preExp;     // Prescale exponent, factor 2**exp
        logic [1:0] pinFunc;    // Dual pin function
        logic       shutdown;   // Stops counting
    } ctrl_t;

    typedef struct packed {
        logic       pin;        // Dual-function pin level
        logic       scl;        // Serial clock level
        logic       sda;        // Serial data level
        logic       uvlo;       // Undervoltage flag
        logic [2:0] vbat;       // Below 3.0, 2.9, 2.8 V
    } pins_t;

endpackage

// *** core/charge_gauge_core.sv ***
// Digital core: dual-function pin, charge counter, alerts and register slave
`timescale 1ns/10ps
// Operation
// (R1) Pin function chosen by control field
// (R2) Pin defaults to alert after reset
// (R3) Alert mode drives pin low on limit
// (R4) Charge-done high loads charge with ones
// (R5) Charge-done pulse of one microsecond recognised
// (R6) Threshold codes select 2.8, 2.9, 3.0 V
// (R7) Count weight scales with prescale over 128
// (R8) Clock line input only, data bidirectional; here the data output is never enabled
// (R9) Any status except ID, recovery drives alert
// (R10) Charge saturates at ends, no wrap
// (R11) Low battery sets alert bit, 00 off
// (R12) Charge-done input synchronised before use
module charge_gauge_core
    import gauge_pkg::*;
#(
    parameter logic CHIP_ID = 1'b0      // Arbitrary identity bit
) (
    input  wire  logic        mclk,
    input  wire  logic        rst_b,
    input  wire  logic        hsel,
    input  wire  logic [31:0] haddr,
    input  wire  logic [1:0]  htrans,
    input  wire  logic        hwrite,
    input  wire  logic [2:0]  hsize,
    input  wire  logic [31:0] hwdata,
    input  wire  logic        hready,
    output logic              hreadyout,
    output logic              hresp,
    output logic [31:0]       hrdata,
    input  wire  logic        rampFlip,
    input  wire  logic        rampUp,
    input  wire  logic        uvloIn,
    input  wire  logic [2:0]  vbatBelow,
    input  wire  logic        sclIn,
    input  wire  logic        sdaIn,
    output logic              sdaOut,
    output logic              sdaOeB,
    input  wire  logic        pinIn,
    output logic              pinOut,
    output logic              pinOeB,
    output logic              irq
);

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    // Last prescaler value for factor 2**e
    function automatic logic [6:0] preTop(input logic [2:0] e);
        logic [7:0] m;
        m = 8'h01 << e;
        return 7'(m - 8'h01);
    endfunction
    // ------------------------------------------------------------
    // Pin synchroniser
    // ------------------------------------------------------------
    pins_t syncA_r, syncA_nxt;      // First stage, read only by second
    pins_t syncB_r, syncB_nxt;      // Settled levels
    // Two stages for every pin and analog flag
    always_comb begin
        syncA_nxt = '{pin: pinIn, scl: sclIn, sda: sdaIn,
                      uvlo: uvloIn, vbat: vbatBelow};   // [R12]
        syncB_nxt = syncA_r;
    end
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            syncA_r <= '0;
            syncB_r <= '0;
        end else begin
            syncA_r <= syncA_nxt;
            syncB_r <= syncB_nxt;
        end
    end
    // ------------------------------------------------------------
    // Serial line monitor
    // ------------------------------------------------------------
    logic       sclPrev_r, sclPrev_nxt;     // Clock level one cycle ago
    logic       sdaPrev_r, sdaPrev_nxt;     // Data level one cycle ago
    logic [7:0] startCnt_r, startCnt_nxt;   // Start conditions seen
    logic       startSeen;
    // Count data falling while clock high; clock is never driven
    always_comb begin
        sclPrev_nxt  = syncB_r.scl;
        sdaPrev_nxt  = syncB_r.sda;
        startSeen    = syncB_r.scl && sclPrev_r && sdaPrev_r && !syncB_r.sda;
        startCnt_nxt = startCnt_r + 8'(startSeen);
    end
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            sclPrev_r  <= 1'b1;
            sdaPrev_r  <= 1'b1;
            startCnt_r <= '0;
        end else begin
            sclPrev_r  <= sclPrev_nxt;
            sdaPrev_r  <= sdaPrev_nxt;
            startCnt_r <= startCnt_nxt;
        end
    end
    // Data line stays released; clock has no output at all
    assign sdaOut = 1'b0;   // [R8]
    assign sdaOeB = 1'b1;   // [R8]
    // ------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------
    logic        wrPend_r, wrPend_nxt;      // Write data phase pending
    logic [5:0]  wrIdx_r, wrIdx_nxt;        // Index of pending write
    logic [31:0] rdata_r, rdata_nxt;        // Read data, held in data phase
    logic        accept;
    logic        rdStatus;
    logic [5:0]  aIdx;
    logic [7:0]  wByte;
    ctrl_t       ctrl_r, ctrl_nxt;
    logic [7:0]  stat_r, stat_nxt;
    logic [15:0] charge_r, charge_nxt;
    logic [15:0] thrHi_r, thrHi_nxt;
    logic [15:0] thrLo_r, thrLo_nxt;
    logic [7:0]  mask_r, mask_nxt;
    assign hreadyout = 1'b1;    // No wait states
    assign hresp     = 1'b0;    // Always OKAY
    assign hrdata    = rdata_r;
    assign aIdx      = haddr[7:2];
    assign accept    = hsel && hready && htrans[1];
    assign rdStatus  = accept && !hwrite && aIdx == IDX_STATUS;
    assign wByte     = hwdata[7:0];
    // Capture address phase; read data sampled at the same edge
    always_comb begin
        wrPend_nxt = accept && hwrite;
        wrIdx_nxt  = accept ? aIdx : wrIdx_r;
        rdata_nxt  = rdata_r;
        if (accept && !hwrite) begin
            if (aIdx == IDX_STATUS) begin
                rdata_nxt = {24'h0, CHIP_ID, stat_r[6:0]};
            end else if (aIdx == IDX_CTRL) begin
                rdata_nxt = {24'h0, ctrl_r};
            end else if (aIdx == IDX_CHG_HI) begin
                rdata_nxt = {24'h0, charge_r[15:8]};
            end else if (aIdx == IDX_CHG_LO) begin
                rdata_nxt = {24'h0, charge_r[7:0]};
            end else if (aIdx == IDX_THH_HI) begin
                rdata_nxt = {24'h0, thrHi_r[15:8]};
            end else if (aIdx == IDX_THH_LO) begin
                rdata_nxt = {24'h0, thrHi_r[7:0]};
            end else if (aIdx == IDX_THL_HI) begin
                rdata_nxt = {24'h0, thrLo_r[15:8]};
            end else if (aIdx == IDX_THL_LO) begin
                rdata_nxt = {24'h0, thrLo_r[7:0]};
            end else if (aIdx == IDX_MASK) begin
                rdata_nxt = {24'h0, mask_r};
            end else if (aIdx == IDX_LINK) begin
                rdata_nxt = {16'h0, startCnt_r, 6'h0, syncB_r.sda, syncB_r.scl};
            end else begin
                rdata_nxt = 32'h0;  // Unmapped reads zero
            end
        end
    end
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            wrPend_r <= 1'b0;
            wrIdx_r  <= '0;
            rdata_r  <= '0;
        end else begin
            wrPend_r <= wrPend_nxt;
            wrIdx_r  <= wrIdx_nxt;
            rdata_r  <= rdata_nxt;
        end
    end
    // ------------------------------------------------------------
    // Counter, limits and status
    // ------------------------------------------------------------
    logic [6:0] pre_r, pre_nxt;         // Prescaler
    logic [4:0] ccCnt_r, ccCnt_nxt;     // Charge-done high time
    logic       alertDrv_r, alertDrv_nxt;
    logic       irq_r, irq_nxt;
    logic       ccMode;
    logic       ccLoad;
    logic       stepUp;
    logic       stepDn;
    logic       vbatHit;
    logic       chWr;
    logic [7:0] cond;
    assign ccMode = ctrl_r.pinFunc == PIN_CHARGE;
    assign ccLoad = ccMode && syncB_r.pin && ccCnt_r == 5'(CC_FILT_CYC);
    assign chWr   = wrPend_r && (wrIdx_r == IDX_CHG_HI || wrIdx_r == IDX_CHG_LO);
    // Prescaler carries step the charge once per 2**exp ramp flips
    always_comb begin
        stepUp = 1'b0;
        stepDn = 1'b0;
        pre_nxt = (pre_r > preTop(ctrl_r.preExp)) ? 7'h00 : pre_r;
        if (rampFlip && !ctrl_r.shutdown) begin
            if (rampUp) begin
                stepUp  = pre_nxt == preTop(ctrl_r.preExp);     // [R7]
                pre_nxt = stepUp ? 7'h00 : pre_nxt + 7'h01;
            end else begin
                stepDn  = pre_nxt == 7'h00;                     // [R7]
                pre_nxt = stepDn ? preTop(ctrl_r.preExp) : pre_nxt - 7'h01;
            end
        end
    end
    // Threshold selection; code 00 never alerts
    always_comb begin
        case (ctrl_r.vbatSel)                                   // [R6]
            VBAT_2V8: vbatHit = syncB_r.vbat[0];                // [R11]
            VBAT_2V9: vbatHit = syncB_r.vbat[1];
            VBAT_3V0: vbatHit = syncB_r.vbat[2];
            default:  vbatHit = 1'b0;
        endcase
    end
    // Next state of registers, charge, filter and outputs
    always_comb begin
        ctrl_nxt   = ctrl_r;
        thrHi_nxt  = thrHi_r;
        thrLo_nxt  = thrLo_r;
        mask_nxt   = mask_r;
        charge_nxt = charge_r;
        cond       = 8'h00;
        // Saturate at both ends and flag it
        if (stepUp) begin
            if (charge_r == CHARGE_TOP) begin
                cond[ST_OVF] = 1'b1;                            // [R10]
            end else begin
                charge_nxt = charge_r + 16'h0001;
            end
        end else if (stepDn) begin
            if (charge_r == CHARGE_BOT) begin
                cond[ST_OVF] = 1'b1;                            // [R10]
            end else begin
                charge_nxt = charge_r - 16'h0001;
            end
        end
        // Software writes land in the data phase
        if (wrPend_r) begin
            if (wrIdx_r == IDX_CTRL) begin
                ctrl_nxt = wByte;                               // [R1]
            end else if (wrIdx_r == IDX_CHG_HI) begin
                charge_nxt[15:8] = wByte;
            end else if (wrIdx_r == IDX_CHG_LO) begin
                charge_nxt[7:0] = wByte;
            end else if (wrIdx_r == IDX_THH_HI) begin
                thrHi_nxt[15:8] = wByte;
            end else if (wrIdx_r == IDX_THH_LO) begin
                thrHi_nxt[7:0] = wByte;
            end else if (wrIdx_r == IDX_THL_HI) begin
                thrLo_nxt[15:8] = wByte;
            end else if (wrIdx_r == IDX_THL_LO) begin
                thrLo_nxt[7:0] = wByte;
            end else if (wrIdx_r == IDX_MASK) begin
                mask_nxt = wByte;
            end
        end
        // Charge-done load wins over everything
        if (ccLoad) begin
            charge_nxt = CHARGE_TOP;                            // [R4]
        end
        // Filter: pulse must stay high before it counts
        if (ccMode && syncB_r.pin) begin
            ccCnt_nxt = (ccCnt_r == 5'(CC_FILT_CYC)) ? ccCnt_r : ccCnt_r + 5'h01;  // [R5]
        end else begin
            ccCnt_nxt = 5'h00;
        end
        // Live conditions; set wins over the clearing read
        cond[ST_HIGH] = charge_r > thrHi_r;
        cond[ST_LOW]  = charge_r < thrLo_r;
        cond[ST_VBAT] = vbatHit;                                // [R11]
        cond[ST_UVLO] = syncB_r.uvlo;
        stat_nxt = ((rdStatus ? 8'h00 : stat_r) | cond) & ST_USED;
        // Alert pin pulls low on any status bit but recovery
        alertDrv_nxt = ctrl_r.pinFunc == PIN_ALERT && |stat_r[ST_OVF:ST_VBAT];  // [R3] [R9]
        irq_nxt = |(stat_r & mask_r);
    end
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_r     <= CTRL_RST;                             // [R2]
            stat_r     <= 8'h00;
            charge_r   <= CHARGE_RST;
            thrHi_r    <= THR_HI_RST;
            thrLo_r    <= THR_LO_RST;
            mask_r     <= MASK_RST;
            pre_r      <= 7'h00;
            ccCnt_r    <= 5'h00;
            alertDrv_r <= 1'b0;
            irq_r      <= 1'b0;
        end else begin
            ctrl_r     <= ctrl_nxt;
            stat_r     <= stat_nxt;
            charge_r   <= charge_nxt;
            thrHi_r    <= thrHi_nxt;
            thrLo_r    <= thrLo_nxt;
            mask_r     <= mask_nxt;
            pre_r      <= pre_nxt;
            ccCnt_r    <= ccCnt_nxt;
            alertDrv_r <= alertDrv_nxt;
            irq_r      <= irq_nxt;
        end
    end
    // Pin drives low only while the alert is active
    assign pinOut = 1'b0;
    assign pinOeB = !alertDrv_r;                                // [R3]
    assign irq    = irq_r;
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    sequence sUpAtTop;
        rampFlip && rampUp && !ctrl_r.shutdown && pre_r == preTop(ctrl_r.preExp);
    endsequence

    sequence sQuietCharge;
        !ccLoad && !chWr;
    endsequence

    AST_PIN_MODE: assert property (ctrl_r.pinFunc != PIN_ALERT |=> pinOeB)  // [R1]
        else $error("pin driven outside alert mode");
    AST_CTRL_ONLY_BY_WRITE: assert property ($changed(ctrl_r) |-> $past(wrPend_r && wrIdx_r == IDX_CTRL))  // [R2]
        else $error("control changed without a write");
    AST_ALERT_DRIVE: assert property (ctrl_r.pinFunc == PIN_ALERT && |stat_r[5:1] |=> !pinOeB)  // [R3]
        else $error("alert not driven");
    AST_CC_LOAD: assert property (ccLoad |=> charge_r == CHARGE_TOP)  // [R4]
        else $error("charge-done load missed");
    AST_CC_WIDTH: assert property (ccMode && syncB_r.pin && !$past(syncB_r.pin) ##1 (ccMode && syncB_r.pin)[*8]
        ##1 (ccMode && syncB_r.pin)[*5] |-> ccLoad)  // [R5]
        else $error("long charge-done pulse not seen");
    AST_VBAT: assert property (vbatHit |=> stat_r[ST_VBAT] && (ctrl_r.vbatSel != VBAT_OFF || !vbatHit))  // [R11]
        else $error("battery alert not set");
    AST_STEP_UP: assert property (sUpAtTop ##0 sQuietCharge ##0 (charge_r != CHARGE_TOP)
        |=> charge_r == $past(charge_r) + 16'h0001 && pre_r == 7'h00)  // [R7]
        else $error("charge step at prescaler carry wrong");
    AST_SATURATE: assert property (sUpAtTop ##0 sQuietCharge ##0 (charge_r == CHARGE_TOP)
        |=> charge_r == CHARGE_TOP && stat_r[ST_OVF])  // [R10]
        else $error("charge wrapped at top");
    AST_IRQ: assert property (|(stat_r & mask_r) |=> irq ##1 (irq || !$past(|(stat_r & mask_r))))
        else $error("interrupt not raised");

endmodule // charge_gauge_core

// *** bench/charger_host_model.sv ***
// Far-side model: charger output on the dual pin, serial host on the bus lines
`timescale 1ns/10ps
module charger_host_model (
    input  wire logic mclk,
    input  wire logic pinOeB,
    input  wire logic pinOut,
    input  wire logic sdaOeB,
    input  wire logic sdaOut,
    output logic      pinLevel,
    output logic      sclLevel,
    output logic      sdaLevel
);
    // ------------------------------------------------------------
    // Wires
    // ------------------------------------------------------------
    logic chgAttached;  // Charger output joined to the pin
    logic chgHigh;      // Charger charge-complete level
    logic sdaHost;      // Host data drive, 1 = released

    // Device pull-down wins, else the charger, else the pull-up
    assign pinLevel = !pinOeB ? pinOut : (chgAttached ? chgHigh : 1'b1);
    // Open-drain data line with pull-up
    assign sdaLevel = sdaHost & (sdaOeB | sdaOut);

    initial begin
        chgAttached = 1'b0;
        chgHigh = 1'b0;
        sclLevel = 1'b1;
        sdaHost = 1'b1;
    end

    // Joins or parts the charger from the pin
    task automatic attach(input logic on);
        chgAttached <= on;
    endtask

    // Charge-complete pulse held high for a number of cycles
    task automatic ccPulse(input int cyc);
        @(posedge mclk);
        chgHigh <= 1'b1;
        repeat (cyc) @(posedge mclk);
        chgHigh <= 1'b0;
    endtask

    // Start, eight bits, stop; the clock line stands high between frames
    task automatic frame(input logic [7:0] b);
        #7;
        sdaHost = 1'b0;
        #160;
        for (int i = 7; i >= 0; i--) begin
            sclLevel = 1'b0;
            sdaHost = b[i];
            #160;
            sclLevel = 1'b1;
            #160;
        end
        sclLevel = 1'b0;
        sdaHost = 1'b0;
        #160;
        sclLevel = 1'b1;
        #160;
        sdaHost = 1'b1;
    endtask
endmodule // charger_host_model

// *** bench/alert_charge_done_pin_logic_tb.sv ***
// Self-checking bench for the dual pin, charge counter and alert logic
`timescale 1ns/10ps
module alert_charge_done_pin_logic_tb
    import gauge_pkg::*;
;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic        mclk, rst_b, hsel, hwrite, hreadyout, hresp;  // Clock, reset, bus
    logic [31:0] haddr, hwdata, hrdata;                         // Bus address and data
    logic [1:0]  htrans;                                        // Transfer kind
    logic [2:0]  hsize, vbatBelow;                              // Size, battery levels
    logic        rampFlip, rampUp, uvloIn, sdaOut, sdaOeB;      // Integrator, lines
    logic        pinOut, pinOeB, irq, pinLevel, sclLevel, sdaLevel;
    int          miscompares, n_checks;                         // Counters

    charge_gauge_core u_charge_gauge_core (.mclk(mclk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .rampFlip(rampFlip), .rampUp(rampUp),
        .uvloIn(uvloIn), .vbatBelow(vbatBelow), .sclIn(sclLevel), .sdaIn(sdaLevel), .sdaOut(sdaOut),
        .sdaOeB(sdaOeB), .pinIn(pinLevel), .pinOut(pinOut), .pinOeB(pinOeB), .irq(irq));
    charger_host_model u_charger_host_model (.mclk(mclk), .pinOeB(pinOeB), .pinOut(pinOut),
        .sdaOeB(sdaOeB), .sdaOut(sdaOut), .pinLevel(pinLevel), .sclLevel(sclLevel), .sdaLevel(sdaLevel));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic summarize;
        $display("Checks %0d, mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Compares a value with its expectation
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask
    // Waits for hready under a bound
    task automatic waitReady;
        int n;
        n = 0;
        @(posedge mclk);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 100) begin
                miscompares++;
                summarize();
            end
            @(posedge mclk);
        end
    endtask
    // One single word transfer: address phase, then data phase
    task automatic bus(input logic wr, input logic [5:0] idx, input logic [7:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h000000, idx, 2'b00};
        hwrite <= wr;
        waitReady();
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= {24'h000000, wd};
        waitReady();
        rd = hrdata;
    endtask
    task automatic wr(input logic [5:0] idx, input logic [7:0] v);
        logic [31:0] d;
        bus(1'b1, idx, v, d);
    endtask
    task automatic rdChk(input logic [5:0] idx, input logic [31:0] exp);
        logic [31:0] d;
        bus(1'b0, idx, 8'h00, d);
        chk(d, exp);
    endtask
    // Integrator direction reversals, one cycle pulses
    task automatic flip(input int n);
        repeat (n) begin
            rampFlip <= 1'b1;
            @(posedge mclk);
            rampFlip <= 1'b0;
            cyc(2);
        end
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic testReset;
        chk(pinOeB, 32'h1);
        chk({hreadyout, hresp}, 32'h2);
        rdChk(IDX_CTRL, 32'h3C);
        rdChk(IDX_CHG_HI, 32'h7F);
        rdChk(IDX_CHG_LO, 32'hFF);
        rdChk(IDX_STATUS, 32'h00);
        wr(6'h0A, 8'h55);
        rdChk(6'h0A, 32'h00);
        $display("Reset test done");
    endtask
    // Short pulse refused, full pulse loads all ones
    task automatic testChargeDone;
        wr(IDX_CTRL, 8'h3A);
        u_charger_host_model.attach(1'b1);
        cyc(4);
        u_charger_host_model.ccPulse(10);
        cyc(30);
        rdChk(IDX_CHG_HI, 32'h7F);
        chk(pinOeB, 32'h1);
        u_charger_host_model.ccPulse(25);
        cyc(30);
        rdChk(IDX_CHG_HI, 32'hFF);
        rdChk(IDX_CHG_LO, 32'hFF);
        wr(IDX_CTRL, CTRL_RST);
        u_charger_host_model.attach(1'b0);
        $display("Charge-done test done");
    endtask
    // Limit crossed pulls the pin low; other functions release it
    task automatic testAlert;
        wr(IDX_THH_HI, 8'h80);
        cyc(6);
        chk(pinOeB, 32'h0);
        chk(pinLevel, 32'h0);
        rdChk(IDX_STATUS, 32'h08);
        chk(irq, 32'h0);
        wr(IDX_CTRL, 8'h38);
        cyc(4);
        chk(pinOeB, 32'h1);
        wr(IDX_CTRL, 8'h3E);
        cyc(4);
        chk(pinOeB, 32'h1);
        wr(IDX_CTRL, CTRL_RST);
        wr(IDX_THH_HI, 8'hFF);
        cyc(4);
        rdChk(IDX_STATUS, 32'h08);
        cyc(4);
        chk(pinOeB, 32'h1);
        rdChk(IDX_STATUS, 32'h00);
        $display("Alert test done");
    endtask
    // Every threshold code, levels just above and just below it
    task automatic testVbat;
        logic [31:0] d;
        logic [2:0]  onPat;
        wr(IDX_MASK, 8'h02);
        for (int c = 0; c < 4; c++) begin
            onPat = (c == 0) ? 3'b111 : 3'(3'b111 << (c - 1));
            wr(IDX_CTRL, {c[1:0], 3'b111, PIN_ALERT, 1'b0});
            vbatBelow <= 3'(3'b111 << c);
            cyc(8);
            bus(1'b0, IDX_STATUS, 8'h00, d);
            rdChk(IDX_STATUS, 32'h00);
            chk(irq, 32'h0);
            vbatBelow <= onPat;
            cyc(8);
            chk(irq, 32'(c != 0));
            chk(pinOeB, 32'(c == 0));
            rdChk(IDX_STATUS, (c != 0) ? 32'h02 : 32'h00);
        end
        wr(IDX_MASK, 8'h00);
        cyc(3);
        chk(irq, 32'h0);
        vbatBelow <= 3'b000;
        cyc(8);
        bus(1'b0, IDX_STATUS, 8'h00, d);
        rdChk(IDX_STATUS, 32'h00);
        $display("Battery threshold test done");
    endtask
    // Saturation at the top, reversal, and prescale weight
    task automatic testCount;
        wr(IDX_CTRL, 8'h04);
        wr(IDX_CHG_HI, 8'hFF);
        wr(IDX_CHG_LO, 8'hFE);
        rampUp <= 1'b1;
        flip(3);
        rdChk(IDX_CHG_LO, 32'hFF);
        rdChk(IDX_STATUS, 32'h20);
        rampUp <= 1'b0;
        flip(1);
        rdChk(IDX_CHG_LO, 32'hFE);
        wr(IDX_CTRL, 8'h14);
        wr(IDX_CHG_HI, 8'h10);
        wr(IDX_CHG_LO, 8'h00);
        rampUp <= 1'b1;
        flip(3);
        rdChk(IDX_CHG_LO, 32'h00);
        flip(1);
        rdChk(IDX_CHG_LO, 32'h01);
        wr(IDX_CTRL, 8'h15);
        flip(4);
        rdChk(IDX_CHG_LO, 32'h01);
        $display("Counter test done");
    endtask
    // One serial frame: clock seen as input, data never driven
    task automatic testLink;
        u_charger_host_model.frame(8'hC8);
        cyc(4);
        rdChk(IDX_LINK, 32'h0103);
        chk(sdaOeB, 32'h1);
        $display("Link test done");
    endtask
    // Recovery flag is sticky but never pulls the pin low
    task automatic testUvlo;
        uvloIn <= 1'b1;
        cyc(6);
        chk(pinOeB, 32'h1);
        rdChk(IDX_STATUS, 32'h01);
        uvloIn <= 1'b0;
        cyc(4);
        rdChk(IDX_STATUS, 32'h01);
        rdChk(IDX_STATUS, 32'h00);
        chk(pinOeB, 32'h1);
        $display("Undervoltage test done");
    endtask

    // ------------------------------------------------------------
    // Clock, watchdog and main sequence
    // ------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    initial begin
        repeat (20000) @(posedge mclk);
        miscompares++;
        summarize();
    end
    initial begin
        rst_b = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0;
        rampFlip = 1'b0;
        rampUp = 1'b1;
        uvloIn = 1'b0;
        vbatBelow = 3'b000;
        miscompares = 0;
        n_checks = 0;
        cyc(5);
        rst_b <= 1'b1;
        @(posedge mclk);
        testReset();
        testChargeDone();
        testAlert();
        testVbat();
        testCount();
        testLink();
        testUvlo();
        summarize();
    end
endmodule // alert_charge_done_pin_logic_tb
